// ---- rtl/tick_counter_regs.vh ----
// Constants of the 16-bit counter core and its byte-wide access path
`ifndef TICK_COUNTER_REGS_VH
`define TICK_COUNTER_REGS_VH

// ****************************************
// Register locations on the 8-bit I/O bus
// ****************************************
`define ADDR_CTRL_A 4'h0
`define ADDR_CTRL_B 4'h1
`define ADDR_CNT_LO 4'h2
`define ADDR_CNT_HI 4'h3
`define ADDR_MATCH_A_LO 4'h4
`define ADDR_MATCH_A_HI 4'h5
`define ADDR_MATCH_B_LO 4'h6
`define ADDR_MATCH_B_HI 4'h7
`define ADDR_SNAP_LO 4'h8
`define ADDR_SNAP_HI 4'h9
`define ADDR_FLAGS 4'hA

// ****************************************
// Field positions
// ****************************************
`define CTRL_A_WAVE_LSB 0
`define CTRL_B_TICK_LSB 0
`define CTRL_B_TICK_MSB 2
`define CTRL_B_WAVE_LSB 3
`define FLAGS_WRAP_BIT 0

// ****************************************
// Reset values and fixed levels
// ****************************************
`define CTRL_A_RST 8'h00
`define CTRL_B_RST 8'h00
`define STAGE_RST 8'h00
`define CNT_RST 16'h0000
`define MATCH_RST 16'h0000
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF

// ****************************************
// Tick source codes
// ****************************************
`define TICK_STOP 3'h0
`define TICK_DIV1 3'h1
`define TICK_DIV8 3'h2
`define TICK_DIV64 3'h3
`define TICK_DIV256 3'h4
`define TICK_DIV1024 3'h5
`define TICK_EXT_FALL 3'h6
`define TICK_EXT_RISE 3'h7

`endif

// ---- rtl/tick_source.v ----
// Tick source selection: prescaler taps and synchronised external edge
`timescale 1ns/1ps
`include "tick_counter_regs.vh"

module tick_source (
	clk,
	sys_rst,
	tick_source_select,
	ext_tick_pin,
	tick_clock
);
	input wire clk;
	input wire sys_rst;
	input wire [2:0] tick_source_select;
	input wire ext_tick_pin;
	output reg tick_clock;

	reg [9:0] div_ff; // Free-running prescale counter
	reg sync1_ff; // First synchroniser stage, read only by sync2_ff
	reg sync2_ff; // Second synchroniser stage
	reg sync3_ff; // Previous level for edge detection
	wire [9:0] nxt_div;

	assign nxt_div = div_ff + 10'h001;

	// ****************************************
	// Prescaler and pin synchroniser
	// ****************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			div_ff <= 10'h000;
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			sync3_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			sync1_ff <= ext_tick_pin;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// Tap selection; code zero gives no ticks at all
	always @* begin
		case (tick_source_select)
			`TICK_STOP: tick_clock = 1'b0;
			`TICK_DIV1: tick_clock = 1'b1;
			`TICK_DIV8: tick_clock = (div_ff[2:0] == 3'h7);
			`TICK_DIV64: tick_clock = (div_ff[5:0] == 6'h3F);
			`TICK_DIV256: tick_clock = (div_ff[7:0] == 8'hFF);
			`TICK_DIV1024: tick_clock = (div_ff == 10'h3FF);
			`TICK_EXT_FALL: tick_clock = sync3_ff & ~sync2_ff;
			`TICK_EXT_RISE: tick_clock = ~sync3_ff & sync2_ff;
			default: tick_clock = 1'b0;
		endcase
	end
endmodule

// ---- rtl/tick_counter.v ----
// Sixteen-bit timer counter core with shared high-byte staging access
`timescale 1ns/1ps
`include "tick_counter_regs.vh"

module tick_counter (
	clk,
	sys_rst,
	bus_addr,
	bus_wdata,
	bus_wr,
	bus_rd,
	bus_rdata,
	ext_tick_pin,
	snap_load,
	snap_data,
	wrap_irq,
	count_top,
	count_bottom,
	count_value,
	match_value_a,
	match_value_b,
	snapshot_value,
	wave_mode_select
);
	input wire clk;
	input wire sys_rst;
	input wire [3:0] bus_addr;
	input wire [7:0] bus_wdata;
	input wire bus_wr;
	input wire bus_rd;
	output reg [7:0] bus_rdata;
	input wire ext_tick_pin;
	input wire snap_load;
	input wire [15:0] snap_data;
	output wire wrap_irq;
	output wire count_top;
	output wire count_bottom;
	output wire [15:0] count_value;
	output wire [15:0] match_value_a;
	output wire [15:0] match_value_b;
	output wire [15:0] snapshot_value;
	output wire [3:0] wave_mode_select;

	// ****************************************
	// State
	// ****************************************
	reg [7:0] timer_control_a_ff; // Wave mode low bits
	reg [7:0] timer_control_b_ff; // Tick select and wave mode high bits
	reg [7:0] stage_ff; // Shared high-byte staging register
	reg [15:0] count_ff; // The counter itself
	reg [15:0] match_a_ff; // Match value A, also top in some modes
	reg [15:0] match_b_ff; // Match value B
	reg [15:0] snap_ff; // Snapshot value, top in some modes
	reg down_ff; // Counting direction for dual-slope modes
	reg wrap_flag_ff; // Sticky wrap flag
	reg [7:0] rdata_ff; // Registered read data
	reg [15:0] nxt_count;
	reg nxt_down;
	reg [15:0] top_val;
	reg dual_slope;
	reg wrap_at_bottom;
	wire tick_clock;
	wire [2:0] tick_source_select;
	wire wr_cnt_lo;
	wire rd_cnt_lo;
	wire rd_snap_lo;
	wire wrap_event;

	// Four-bit mode: two bits from each control register
	assign wave_mode_select = {timer_control_b_ff[`CTRL_B_WAVE_LSB+1:`CTRL_B_WAVE_LSB],
		timer_control_a_ff[`CTRL_A_WAVE_LSB+1:`CTRL_A_WAVE_LSB]};
	assign tick_source_select = timer_control_b_ff[`CTRL_B_TICK_MSB:`CTRL_B_TICK_LSB];
	assign wr_cnt_lo = bus_wr & (bus_addr == `ADDR_CNT_LO);
	assign rd_cnt_lo = bus_rd & (bus_addr == `ADDR_CNT_LO);
	assign rd_snap_lo = bus_rd & (bus_addr == `ADDR_SNAP_LO);
	assign count_value = count_ff;
	assign match_value_a = match_a_ff;
	assign match_value_b = match_b_ff;
	assign snapshot_value = snap_ff;
	assign count_top = (count_ff == top_val);
	assign count_bottom = (count_ff == `CNT_BOTTOM);
	// Plain level; masking and the processor request itself live outside
	assign wrap_irq = wrap_flag_ff;

	// ****************************************
	// Tick source
	// ****************************************
	tick_source u_tick_source (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick_source_select(tick_source_select),
		.ext_tick_pin(ext_tick_pin),
		.tick_clock(tick_clock)
	);

	// ****************************************
	// Mode decode: top value and slope kind
	// ****************************************
	always @* begin
		top_val = `CNT_MAX;
		dual_slope = 1'b0;
		wrap_at_bottom = 1'b0;
		case (wave_mode_select)
			4'h0: top_val = `CNT_MAX; // Normal
			4'h1: begin
				top_val = `TOP_8BIT;
				dual_slope = 1'b1;
			end
			4'h2: begin
				top_val = `TOP_9BIT;
				dual_slope = 1'b1;
			end
			4'h3: begin
				top_val = `TOP_10BIT;
				dual_slope = 1'b1;
			end
			4'h4: top_val = match_a_ff; // Clear on match A
			4'h5: top_val = `TOP_8BIT;
			4'h6: top_val = `TOP_9BIT;
			4'h7: top_val = `TOP_10BIT;
			4'h8, 4'hA: begin
				top_val = snap_ff;
				dual_slope = 1'b1;
			end
			4'h9, 4'hB: begin
				top_val = match_a_ff;
				dual_slope = 1'b1;
			end
			4'hC: top_val = snap_ff; // Clear on snapshot
			4'hE: top_val = snap_ff;
			4'hF: top_val = match_a_ff;
			default: top_val = `CNT_MAX; // Reserved code
		endcase
		// Dual-slope modes wrap at the valley, others at top or max
		wrap_at_bottom = dual_slope;
	end

	// ****************************************
	// Next count from counting logic
	// ****************************************
	always @* begin
		nxt_count = count_ff;
		nxt_down = down_ff;
		if (tick_clock) begin
			if (dual_slope) begin
				// Turn around at either end so the ramp is symmetric
				if (count_ff == top_val) begin
					nxt_down = 1'b1;
					nxt_count = count_ff - 16'h0001;
				end else if (count_ff == `CNT_BOTTOM) begin
					nxt_down = 1'b0;
					nxt_count = count_ff + 16'h0001;
				end else if (down_ff) begin
					nxt_count = count_ff - 16'h0001;
				end else begin
					nxt_count = count_ff + 16'h0001;
				end
			end else if (count_ff == top_val) begin
				nxt_count = `CNT_BOTTOM; // clear at top
				nxt_down = 1'b0;
			end else begin
				nxt_count = count_ff + 16'h0001;
				nxt_down = 1'b0;
			end
		end
	end

	// Wrap point depends on mode; counter write suppresses it with the count
	assign wrap_event = tick_clock & ~wr_cnt_lo &
		(wrap_at_bottom ? (count_ff == `CNT_BOTTOM) :
		(wave_mode_select == 4'h0 ? (count_ff == `CNT_MAX) :
		(count_ff == top_val)));

	// ****************************************
	// Counter and direction
	// ****************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			count_ff <= `CNT_RST;
			down_ff <= 1'b0;
		end else if (wr_cnt_lo) begin
			// Host write overrides any clear or count this cycle
			// Writing while counting is legal; the next tick counts on from here
			count_ff <= {stage_ff, bus_wdata};
			down_ff <= down_ff;
		end else begin
			count_ff <= nxt_count;
			down_ff <= nxt_down;
		end
	end

	// ****************************************
	// Shared staging register
	// ****************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			stage_ff <= `STAGE_RST;
		end else if (bus_wr && (bus_addr == `ADDR_CNT_HI || bus_addr == `ADDR_MATCH_A_HI ||
			bus_addr == `ADDR_MATCH_B_HI || bus_addr == `ADDR_SNAP_HI)) begin
			// High write wins if a host ever strobed read and write together
			stage_ff <= bus_wdata;
		end else if (rd_cnt_lo) begin
			stage_ff <= count_ff[15:8];
		end else if (rd_snap_lo) begin
			stage_ff <= snap_ff[15:8];
		end
		// Otherwise held, match reads leave it alone
	end

	// ****************************************
	// Control, match and snapshot registers
	// ****************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			timer_control_a_ff <= `CTRL_A_RST;
			timer_control_b_ff <= `CTRL_B_RST;
			match_a_ff <= `MATCH_RST;
			match_b_ff <= `MATCH_RST;
			snap_ff <= `MATCH_RST;
		end else begin
			if (bus_wr && bus_addr == `ADDR_CTRL_A) begin
				timer_control_a_ff <= bus_wdata;
			end
			if (bus_wr && bus_addr == `ADDR_CTRL_B) begin
				timer_control_b_ff <= bus_wdata;
			end
			if (bus_wr && bus_addr == `ADDR_MATCH_A_LO) begin
				match_a_ff <= {stage_ff, bus_wdata};
			end
			if (bus_wr && bus_addr == `ADDR_MATCH_B_LO) begin
				match_b_ff <= {stage_ff, bus_wdata};
			end
			// Capture event wins over a host write in the same cycle
			if (snap_load) begin
				snap_ff <= snap_data;
			end else if (bus_wr && bus_addr == `ADDR_SNAP_LO) begin
				snap_ff <= {stage_ff, bus_wdata};
			end
		end
	end

	// ****************************************
	// Wrap flag: set wins over write-one-to-clear
	// ****************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			wrap_flag_ff <= 1'b0;
		end else if (wrap_event) begin
			wrap_flag_ff <= 1'b1;
		end else if (bus_wr && bus_addr == `ADDR_FLAGS && bus_wdata[`FLAGS_WRAP_BIT]) begin
			wrap_flag_ff <= 1'b0;
		end
	end

	// ****************************************
	// Read data, registered one cycle after strobe
	// ****************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			rdata_ff <= 8'h00;
		end else if (bus_rd) begin
			// Only a real strobe updates, since reads have side effects
			case (bus_addr)
				`ADDR_CTRL_A: rdata_ff <= timer_control_a_ff;
				`ADDR_CTRL_B: rdata_ff <= timer_control_b_ff;
				`ADDR_CNT_LO: rdata_ff <= count_ff[7:0];
				`ADDR_CNT_HI: rdata_ff <= stage_ff;
				`ADDR_MATCH_A_LO: rdata_ff <= match_a_ff[7:0];
				`ADDR_MATCH_A_HI: rdata_ff <= match_a_ff[15:8];
				`ADDR_MATCH_B_LO: rdata_ff <= match_b_ff[7:0];
				`ADDR_MATCH_B_HI: rdata_ff <= match_b_ff[15:8];
				`ADDR_SNAP_LO: rdata_ff <= snap_ff[7:0];
				`ADDR_SNAP_HI: rdata_ff <= stage_ff;
				`ADDR_FLAGS: rdata_ff <= {7'h00, wrap_flag_ff};
				default: rdata_ff <= 8'h00; // Unmapped reads as zero
			endcase
		end
	end

	// Read data output from flip-flops
	always @* begin
		bus_rdata = rdata_ff;
	end
endmodule

// ---- test/tick_counter_props.sv ----
// Port-level assertion checker for the tick counter
`timescale 1ns/1ps
module tick_counter_props (
	input wire clk,
	input wire sys_rst,
	input wire [3:0] bus_addr,
	input wire [7:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	input wire [7:0] bus_rdata,
	input wire wrap_irq,
	input wire count_top,
	input wire count_bottom,
	input wire [15:0] count_value,
	input wire [15:0] match_value_a,
	input wire [15:0] snapshot_value,
	input wire [3:0] wave_mode_select
);
	// ****
	// Shadow state
	// ****
	reg [7:0] stg_ff; // Expected staging byte
	reg [2:0] tick_ff; // Last written tick select
	// Mirror every staging update so high-byte reads can be predicted
	always @(posedge clk) begin
		if (sys_rst) begin
			stg_ff <= 8'h00;
			tick_ff <= 3'h0;
		end else begin
			if (bus_wr && bus_addr[0] && bus_addr >= 4'h3 && bus_addr <= 4'h9)
				stg_ff <= bus_wdata;
			if (bus_rd && bus_addr == 4'h2)
				stg_ff <= count_value[15:8];
			if (bus_rd && bus_addr == 4'h8)
				stg_ff <= snapshot_value[15:8];
			if (bus_wr && bus_addr == 4'h1)
				tick_ff <= bus_wdata[2:0];
		end
	end
	// ****
	// Properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Counter about to roll over in normal mode with no host write
	sequence s_at_max;
		count_value == 16'hFFFF && tick_ff == 3'h1 && $past(tick_ff) == 3'h1 &&
			wave_mode_select == 4'h0 && !bus_wr;
	endsequence
	property p_bottom;
		count_bottom == (count_value == 16'h0000);
	endproperty
	a_bottom: assert property (p_bottom) else $error("bottom flag mismatch");
	property p_top;
		wave_mode_select == 4'h0 |-> count_top == (count_value == 16'hFFFF);
	endproperty
	a_top: assert property (p_top) else $error("top flag mismatch");
	property p_lo_wr;
		bus_wr && bus_addr == 4'h2 |=> count_value == {$past(stg_ff), $past(bus_wdata)};
	endproperty
	a_lo_wr: assert property (p_lo_wr) else $error("counter load wrong");
	property p_match_wr;
		bus_wr && bus_addr == 4'h4 |=> match_value_a == {$past(stg_ff), $past(bus_wdata)};
	endproperty
	a_match_wr: assert property (p_match_wr) else $error("match load wrong");
	property p_hi_rd;
		bus_rd && bus_addr == 4'h3 |=> bus_rdata == $past(stg_ff);
	endproperty
	a_hi_rd: assert property (p_hi_rd) else $error("high read wrong");
	property p_lo_rd;
		bus_rd && bus_addr == 4'h2 |=> bus_rdata == $past(count_value[7:0]);
	endproperty
	a_lo_rd: assert property (p_lo_rd) else $error("low read wrong");
	property p_match_rd;
		bus_rd && bus_addr == 4'h5 |=> bus_rdata == $past(match_value_a[15:8]);
	endproperty
	a_match_rd: assert property (p_match_rd) else $error("match read wrong");
	// Two cycles of stopped select, though the combinational tick needs only one
	property p_stop;
		$past(tick_ff) == 3'h0 && $past(tick_ff, 2) == 3'h0 && !$past(bus_wr)
			|-> $stable(count_value);
	endproperty
	a_stop: assert property (p_stop) else $error("counter moved while stopped");
	property p_step;
		$past(tick_ff) == 3'h1 && $past(tick_ff, 2) == 3'h1 &&
			$past(wave_mode_select) == 4'h0 && !$past(bus_wr)
			|-> count_value == $past(count_value) + 16'h0001;
	endproperty
	a_step: assert property (p_step) else $error("count step wrong");
	property p_wrap;
		s_at_max |=> wrap_irq;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap flag not set");
endmodule

// ---- test/host_bus_model.sv ----
// Host processor model on the byte-wide register bus
`timescale 1ns/1ps
module host_bus_model (
	input wire clk,
	output reg [3:0] bus_addr,
	output reg [7:0] bus_wdata,
	output reg bus_wr,
	output reg bus_rd,
	input wire [7:0] bus_rdata
);
	// Idle bus from time zero
	initial begin
		bus_addr = 4'h0;
		bus_wdata = 8'h00;
		bus_wr = 1'h0;
		bus_rd = 1'h0;
	end
	// One strobe cycle; released lines show inverted values, not stale ones
	task acc(input reg w, input reg [3:0] a, input reg [7:0] d, output reg [7:0] q);
		begin
			@(negedge clk);
			bus_addr = a;
			bus_wdata = d;
			bus_wr = w;
			bus_rd = ~w;
			@(negedge clk);
			q = bus_rdata;
			bus_wr = 1'h0;
			bus_rd = 1'h0;
			bus_addr = ~a;
			bus_wdata = ~d;
		end
	endtask
	// High byte first, nothing in between
	task wr16(input reg [3:0] lo, input reg [15:0] v);
		reg [7:0] q;
		begin
			acc(1'h1, lo + 4'h1, v[15:8], q);
			acc(1'h1, lo, v[7:0], q);
		end
	endtask
	// Low byte first, nothing in between
	task rd16(input reg [3:0] lo, output reg [15:0] v);
		begin
			acc(1'h0, lo, 8'h00, v[7:0]);
			acc(1'h0, lo + 4'h1, 8'h00, v[15:8]);
		end
	endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the sixteen-bit tick counter
`timescale 1ns/1ps
`include "tick_counter_regs.vh"
module tb_top;
	reg clk = 1'h0;
	reg sys_rst = 1'h1; // Held for five cycles
	reg ext_tick_pin = 1'h0;
	reg snap_load = 1'h0;
	reg [15:0] snap_data = 16'h0000;
	wire [3:0] bus_addr;
	wire [7:0] bus_wdata, bus_rdata;
	wire bus_wr, bus_rd, wrap_irq, count_top, count_bottom;
	wire [15:0] count_value, match_value_a, match_value_b, snapshot_value;
	wire [3:0] wave_mode_select;
	integer num_errors = 0;
	integer n_compared = 0;
	reg [7:0] q;
	reg [15:0] v;
	always #5 clk = ~clk;
	host_bus_model host (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
	tick_counter dut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.ext_tick_pin(ext_tick_pin), .snap_load(snap_load), .snap_data(snap_data),
		.wrap_irq(wrap_irq), .count_top(count_top), .count_bottom(count_bottom),
		.count_value(count_value), .match_value_a(match_value_a),
		.match_value_b(match_value_b), .snapshot_value(snapshot_value),
		.wave_mode_select(wave_mode_select));
	// Compare and count
	task check(input reg [15:0] seen, input reg [15:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// Verdict and end of run
	task stop_test;
		begin
			$display("compared %0d errors %0d", n_compared, num_errors);
			if (num_errors == 0 && n_compared > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// Bounded wait on top (0) or wrap flag (1); running out is a failure
	task wait_until(input reg sel);
		integer n;
		begin
			n = 0;
			while ((sel ? wrap_irq : count_top) !== 1'h1 && n < 300) begin
				@(negedge clk);
				n = n + 1;
			end
			if ((sel ? wrap_irq : count_top) !== 1'h1) begin
				num_errors = num_errors + 1;
				stop_test;
			end
		end
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (5) @(negedge clk);
		sys_rst = 1'h0;
		check(count_bottom, 1'h1);
		check(count_top, 1'h0);
		host.wr16(`ADDR_CNT_LO, 16'h01FF);
		check(count_value, 16'h01FF);
		repeat (4) @(negedge clk);
		check(count_value, 16'h01FF);
		host.rd16(`ADDR_CNT_LO, v);
		check(v, 16'h01FF);
		host.wr16(`ADDR_MATCH_A_LO, 16'h1234);
		check(match_value_a, 16'h1234);
		// One staged high byte serves two low writes
		host.acc(1'h1, `ADDR_CNT_HI, 8'hAB, q);
		host.acc(1'h1, `ADDR_MATCH_B_LO, 8'h56, q);
		host.acc(1'h1, `ADDR_CNT_LO, 8'h78, q);
		check(match_value_b, 16'hAB56);
		check(count_value, 16'hAB78);
		// Match read between counter halves must not disturb staging
		host.acc(1'h0, `ADDR_CNT_LO, 8'h00, q);
		host.rd16(`ADDR_MATCH_A_LO, v);
		check(v, 16'h1234);
		host.acc(1'h0, `ADDR_CNT_HI, 8'h00, q);
		check(q, 8'hAB);
		@(negedge clk);
		snap_load = 1'h1;
		snap_data = 16'h5AA5;
		@(negedge clk);
		snap_load = 1'h0;
		host.rd16(`ADDR_SNAP_LO, v);
		check(v, 16'h5AA5);
		check(snapshot_value, 16'h5AA5);
		host.acc(1'h0, 4'hF, 8'h00, q);
		check(q, 8'h00);
		host.acc(1'h1, `ADDR_CTRL_A, 8'h03, q);
		host.acc(1'h1, `ADDR_CTRL_B, 8'h18, q);
		check(wave_mode_select, 4'hF);
		host.acc(1'h1, `ADDR_CTRL_A, 8'h00, q);
		host.acc(1'h1, `ADDR_CTRL_B, 8'h07, q);
		host.wr16(`ADDR_CNT_LO, 16'h0010);
		// One rising edge on the external pin gives one count
		ext_tick_pin = 1'h1;
		repeat (8) @(negedge clk);
		check(count_value, 16'h0011);
		ext_tick_pin = 1'h0;
		host.acc(1'h1, `ADDR_CTRL_B, 8'h01, q);
		host.wr16(`ADDR_CNT_LO, 16'hFFF0);
		check(count_value, 16'hFFF0);
		wait_until(1'h0);
		check(count_value, 16'hFFFF);
		wait_until(1'h1);
		check(count_value[15:4], 12'h000);
		host.acc(1'h1, `ADDR_FLAGS, 8'h01, q);
		check(wrap_irq, 1'h0);
		host.acc(1'h1, `ADDR_CTRL_B, 8'h00, q);
		// Falling-edge tick source: the rising edge must not count
		host.wr16(`ADDR_CNT_LO, 16'h0100);
		host.acc(1'h1, `ADDR_CTRL_B, 8'h06, q);
		ext_tick_pin = 1'h1;
		repeat (4) @(negedge clk);
		check(count_value, 16'h0100);
		ext_tick_pin = 1'h0;
		repeat (4) @(negedge clk);
		check(count_value, 16'h0101);
		// Any eight cycles of the divide-by-8 source hold exactly one tick
		host.acc(1'h1, `ADDR_CTRL_B, 8'h02, q);
		repeat (8) @(negedge clk);
		check(count_value, 16'h0102);
		// Dual-slope mode with fixed top 0x00FF: turn at top, wrap at bottom
		host.acc(1'h1, `ADDR_CTRL_B, 8'h01, q);
		host.acc(1'h1, `ADDR_CTRL_A, 8'h01, q);
		check(wave_mode_select, 4'h1);
		host.wr16(`ADDR_CNT_LO, 16'h00FD);
		wait_until(1'h0);
		check(count_value, 16'h00FF);
		@(negedge clk);
		check(count_value, 16'h00FE);
		wait_until(1'h1);
		check(count_value, 16'h0001);
		// Reset in mid-run returns every register to its idle value
		sys_rst = 1'h1;
		repeat (2) @(negedge clk);
		sys_rst = 1'h0;
		check(count_value, 16'h0000);
		check(wrap_irq, 1'h0);
		check(wave_mode_select, 4'h0);
		@(negedge clk);
		check(count_value, 16'h0000);
		stop_test;
	end
endmodule
bind tick_counter tick_counter_props chk (.clk(clk), .sys_rst(sys_rst),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .wrap_irq(wrap_irq), .count_top(count_top),
	.count_bottom(count_bottom), .count_value(count_value),
	.match_value_a(match_value_a), .snapshot_value(snapshot_value),
	.wave_mode_select(wave_mode_select));
